// File: rtl/rtcu_top.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module rtcu_top
  import rtcu_pkg::*;
#(
  parameter int CLK_PER_TICK = CLK_PER_TICK_DEF
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire rtcu_time_s TIME_NOW,
  output logic UPDATE_STROBE,
  output logic BINARY_MODE,
  output logic HOUR24_MODE,
  output logic SUMMER_TIME_EN,
  output logic SQUARE_OUT,
  output logic IRQ_N_O,
  output logic IRQ_N_OE
);

  // A tick divider wider than 13 bits or a one-cycle tick cannot work.
  if (CLK_PER_TICK < 2 || CLK_PER_TICK > 8191) begin : g_bad_div
    $error("CLK_PER_TICK out of range");
  end

  localparam logic [12:0] TICK_LAST = 13'(CLK_PER_TICK - 1);

  rtcu_regs_s r;
  rtcu_regs_s n;

  // ========================================================================
  // Divider tap selection.
  // Code zero selects no tap; codes one and two take slow taps; codes 3 to 15 step one stage per code.
  function automatic logic tap_of(input logic [3:0] rs, input logic [14:0] div);
    logic [3:0] k;
    k = rs - 4'h2;
    if (rs == 4'h0) begin
      tap_of = 1'b0;
    end else if (rs == 4'h1) begin
      tap_of = div[6];
    end else if (rs == 4'h2) begin
      tap_of = div[7];
    end else begin
      tap_of = div[k];
    end
  endfunction

  // Alarm position matches when equal or marked don't-care.
  function automatic logic pos_hit(input logic [7:0] al, input logic [7:0] tm);
    pos_hit = (al[7:6] == DONT_CARE) || (al == tm);
  endfunction

  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic pin_rst;
  logic run;
  logic step;
  logic pf_set;
  logic af_set;
  logic uf_set;
  logic [2:0] clr;
  logic [2:0] en;
  logic [7:0] rdv;
  logic hit;

  // ========================================================================
  // Next-state logic for the whole block.
  always_comb begin
    n = r;
    // The reset pin is asynchronous to MCLK, so it passes two flops.
    n.rp1 = RESET_PIN_N;
    n.rp2 = r.rp1;
    pin_rst = !r.rp2;

    // Oscillator rate enable from the system clock.
    n.tick = 1'b0;
    if (r.tick_cnt == TICK_LAST) begin
      n.tick_cnt = 13'h0000;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 13'h0001;
    end

    // Bus phases; the slave answers one cycle after setup.
    setup = PSEL && !PENABLE;
    acc = PSEL && PENABLE && r.pready;
    wr = acc && PWRITE;
    rd = acc && !PWRITE;

    // Read data is captured in setup, so a flag read is double latched.
    rdv = 8'h00;
    hit = 1'b1;
    n.prdata = 32'h0000_0000;
    if (PADDR == ADDR_CTRL_A) begin
      rdv[A_UIP] = r.update_pending_flag;
      rdv[A_DV_LO +: 3] = r.dv;
      rdv[A_RS_LO +: 4] = r.rs;
      n.prdata = {24'h000000, rdv};
    end else if (PADDR == ADDR_CTRL_B) begin
      n.prdata = {24'h000000, r.ctlb};
    end else if (PADDR == ADDR_FLAGS) begin
      rdv[F_SUMMARY_IRQ_FLAG] = r.irq_oe;
      rdv[F_PF -: 3] = r.flags;
      n.prdata = {24'h000000, rdv};
    end else if (PADDR == ADDR_TIME) begin
      n.prdata = {8'h00, r.user};
    end else if (PADDR == ADDR_ALARM) begin
      n.prdata = {8'h00, r.alarm};
    end else begin
      hit = 1'b0;
    end
    n.pready = setup;
    n.pslverr = setup && !hit;
    if (!setup) begin
      n.prdata = r.prdata;
    end

    run = (r.dv == DV_RUN);
    step = run && r.tick;
    if (r.dv[2:1] == DV_HOLD) begin
      n.div = 15'h0000;
    end else if (step) begin
      n.div = r.div + 15'h0001;
    end

    // Update sequence, paced by the oscillator tick.
    n.strobe = 1'b0;
    uf_set = 1'b0;
    if (!run) begin
      n.state = ST_IDLE;
      n.update_pending_flag = 1'b0;
    end else if (step) begin
      case (r.state)
        ST_IDLE: begin
          // Pending rises as the divider enters the window, a full eight ticks before wrap.
          if (r.div == DIV_PEND - 15'h0001) begin
            n.state = ST_PEND;
            n.update_pending_flag = !r.ctlb[B_FREEZE];
          end
        end
        ST_PEND: begin
          if (r.div == DIV_LAST) begin
            n.strobe = 1'b1;
            n.state = ST_BUSY;
            n.uc_cnt = 6'h00;
          end
        end
        ST_BUSY: begin
          n.uc_cnt = r.uc_cnt + 6'h01;
          if (r.uc_cnt == UC_LAST) begin
            n.state = ST_IDLE;
            n.update_pending_flag = 1'b0;
            uf_set = 1'b1;
          end
        end
        default: begin
          n.state = ST_IDLE;
        end
      endcase
    end

    n.load = r.strobe && r.update_pending_flag;
    if (r.load && !r.ctlb[B_FREEZE]) begin
      n.user = TIME_NOW;
    end
    af_set = r.strobe && pos_hit(r.alarm.sec, TIME_NOW.sec)
             && pos_hit(r.alarm.min, TIME_NOW.min)
             && pos_hit(r.alarm.hour, TIME_NOW.hour);
    // Comparing in the strobe cycle sees the second from before the strobe, not the new second that it makes.
    af_set = af_set && r.load == 1'b0;

    // Register writes take effect at the access edge.
    if (wr && PADDR == ADDR_CTRL_A) begin
      n.dv = PWDATA[A_DV_LO +: 3];
      n.rs = PWDATA[A_RS_LO +: 4];
      if (PWDATA[A_DV_LO +: 3] == DV_RUN && r.dv != DV_RUN) begin
        n.div = DIV_START;
      end
    end
    if (wr && PADDR == ADDR_CTRL_B) begin
      n.ctlb = PWDATA[7:0];
      if (PWDATA[B_FREEZE] && !r.ctlb[B_FREEZE]) begin
        n.ctlb[B_UIE] = 1'b0;
      end
      if (PWDATA[B_FREEZE]) begin
        n.update_pending_flag = 1'b0;
      end
    end
    if (wr && PADDR == ADDR_ALARM) begin
      n.alarm = PWDATA[23:0];
    end

    if (pin_rst) begin
      n.ctlb[B_PIE] = 1'b0;
      n.ctlb[B_AIE] = 1'b0;
      n.ctlb[B_UIE] = 1'b0;
      n.ctlb[B_SQUARE_OUT_ENABLE] = 1'b0;
    end

    n.tap_d = tap_of(r.rs, r.div);
    pf_set = n.tap_d && !r.tap_d;
    // A read clears only the flags it returned, so a new event wins.
    clr = rd && PADDR == ADDR_FLAGS ? r.prdata[F_PF -: 3] : 3'h0;
    n.flags = (r.flags & ~clr) | {pf_set, af_set, uf_set};
    if (pin_rst) begin
      n.flags = 3'h0;
    end

    n.sq = n.ctlb[B_SQUARE_OUT_ENABLE] && n.tap_d;
    en = {n.ctlb[B_PIE], n.ctlb[B_AIE], n.ctlb[B_UIE]};
    n.irq_oe = |(n.flags & en);
  end

  // ========================================================================
  // State register. Power-on reset sets everything; the reset pin acts
  // only through the synchronised path above, so the bits that must
  // survive it (pending flag, rate and divider bits, freeze, format) do.
  // pin keeps bits
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      // The synchroniser idles at the released level, so no false pin reset follows.
      r.rp1 <= 1'b1;
      r.rp2 <= 1'b1;
      r.dv <= DV_RST;
      r.rs <= RS_RST;
      r.ctlb <= CTLB_RST;
      r.state <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ========================================================================
  // Outputs, each from a flop.
  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign UPDATE_STROBE = r.strobe;
  assign BINARY_MODE = r.ctlb[B_BIN];
  assign HOUR24_MODE = r.ctlb[B_H24];
  assign SUMMER_TIME_EN = r.ctlb[B_DST];
  assign SQUARE_OUT = r.sq;
  // Open-drain pin: only ever pulls low.
  assign IRQ_N_O = r.rp2 & 1'b0;
  assign IRQ_N_OE = r.irq_oe;

  // ========================================================================
  // Checks.
  property p_uip_freeze;
    @(posedge MCLK) disable iff (!RST_N)
    (PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_CTRL_B && PWDATA[B_FREEZE])
    |=> !r.update_pending_flag;
  endproperty
  a_uip_freeze: assert property (p_uip_freeze)
    else $error("pending flag not cleared by freeze");

  property p_load_pend;
    @(posedge MCLK) disable iff (!RST_N)
    r.load |-> $past(r.update_pending_flag, 2) && r.state == ST_BUSY;
  endproperty
  a_load_pend: assert property (p_load_pend)
    else $error("user copy loaded without pending flag");

  property p_done_flag;
    @(posedge MCLK) disable iff (!RST_N)
    (r.state == ST_BUSY && r.uc_cnt == UC_LAST && step && !pin_rst) |=> r.flags[0];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("update-done flag not set at cycle end");

  property p_strobe_time;
    @(posedge MCLK) disable iff (!RST_N)
    UPDATE_STROBE |-> r.div == 15'h0000 && r.state == ST_BUSY;
  endproperty
  a_strobe_time: assert property (p_strobe_time)
    else $error("update strobe off the second boundary");

  property p_irq_pin;
    @(posedge MCLK) disable iff (!RST_N)
    IRQ_N_OE == |(r.flags & {r.ctlb[B_PIE], r.ctlb[B_AIE], r.ctlb[B_UIE]});
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin disagrees with flags");

  property p_sq_low;
    @(posedge MCLK) disable iff (!RST_N)
    !r.ctlb[B_SQUARE_OUT_ENABLE] |-> !SQUARE_OUT;
  endproperty
  a_sq_low: assert property (p_sq_low)
    else $error("square output driven while disabled");

  property p_pin_rst;
    @(posedge MCLK) disable iff (!RST_N)
    (pin_rst && !wr) |=> (r.ctlb[6:3] == 4'h0) && $stable(r.rs) && r.flags == 3'h0;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin effect wrong");

  property p_hold;
    @(posedge MCLK) disable iff (!RST_N)
    (r.dv[2:1] == DV_HOLD) ##1 (r.dv[2:1] == DV_HOLD) |-> r.div == 15'h0000;
  endproperty
  a_hold: assert property (p_hold)
    else $error("divider chain not held");

  property p_uie_freeze;
    @(posedge MCLK) disable iff (!RST_N)
    $rose(r.ctlb[B_FREEZE]) |-> !r.ctlb[B_UIE];
  endproperty
  a_uie_freeze: assert property (p_uie_freeze)
    else $error("update-done enable kept when freeze rose");

  property p_alarm_dc;
    @(posedge MCLK) disable iff (!RST_N)
    (r.strobe && r.alarm.sec[7:6] == DONT_CARE && r.alarm.min[7:6] == DONT_CARE
     && r.alarm.hour[7:6] == DONT_CARE && !pin_rst) |=> r.flags[1];
  endproperty
  a_alarm_dc: assert property (p_alarm_dc)
    else $error("alarm flag not set for an all don't-care alarm");

  property p_keep_bits;
    @(posedge MCLK) disable iff (!RST_N)
    (pin_rst && !wr) |=> $stable(r.ctlb[B_FREEZE]) && $stable(r.ctlb[B_BIN])
                         && $stable(r.ctlb[B_H24]) && $stable(r.dv);
  endproperty
  a_keep_bits: assert property (p_keep_bits)
    else $error("reset pin changed a kept control bit");

endmodule

// File: rtl/rtcu_pkg.sv
// ==========================================================================
// Shared constants and types of the update and control block.
package rtcu_pkg;
  // Clock rates; the oscillator rate is the divider chain input.
  localparam int CLK_HZ = 250000000;
  localparam int OSC_HZ = 32768;
  // Times as printed, in their own units.
  localparam int PRE_UPDATE_DELAY_US = 244;
  localparam int T_UC_US = 1708;
  localparam int T_FIRST_MS = 500;
  // Oscillator ticks derived from the times; least times round up.
  localparam int BUC_TICKS = (PRE_UPDATE_DELAY_US * OSC_HZ + 999999) / 1000000;
  localparam int UC_TICKS = (T_UC_US * OSC_HZ + 999999) / 1000000;
  localparam int CLK_PER_TICK_DEF = CLK_HZ / OSC_HZ;
  localparam logic [14:0] DIV_PEND = 15'(OSC_HZ - BUC_TICKS);
  localparam logic [14:0] DIV_START = 15'(OSC_HZ - T_FIRST_MS * OSC_HZ / 1000);
  localparam logic [14:0] DIV_LAST = 15'h7FFF;
  localparam logic [5:0] UC_LAST = 6'(UC_TICKS - 1);
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_TIME = 8'h0C;
  localparam logic [7:0] ADDR_ALARM = 8'h10;
  // Field positions.
  localparam int A_UIP = 7;
  localparam int A_DV_LO = 4;
  localparam int A_RS_LO = 0;
  localparam int B_FREEZE = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_SQUARE_OUT_ENABLE = 3;
  localparam int B_BIN = 2;
  localparam int B_H24 = 1;
  localparam int B_DST = 0;
  localparam int F_SUMMARY_IRQ_FLAG = 7;
  localparam int F_PF = 6;
  // Codes and reset values.
  localparam logic [2:0] DV_RUN = 3'h2;
  localparam logic [1:0] DV_HOLD = 2'h3;
  localparam logic [2:0] DV_RST = 3'h0;
  localparam logic [3:0] RS_RST = 4'h0;
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [1:0] DONT_CARE = 2'h3;

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_PEND = 2'h1, ST_BUSY = 2'h3} rtcu_state_e;

  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcu_time_s;

  typedef struct packed {
    logic rp1;
    logic rp2;
    logic [12:0] tick_cnt;
    logic tick;
    logic [14:0] div;
    rtcu_state_e state;
    logic [5:0] uc_cnt;
    logic update_pending_flag;
    logic strobe;
    logic load;
    logic [2:0] dv;
    logic [3:0] rs;
    logic [7:0] ctlb;
    logic [2:0] flags;
    logic tap_d;
    rtcu_time_s alarm;
    rtcu_time_s user;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sq;
    logic irq_oe;
  } rtcu_regs_s;
endpackage

// File: verification/rtcu_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host processor stand-in: an APB master, one transfer at a time.
module rtcu_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus idles deselected.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // The request is held until pready is seen high at a rising edge, so a slow slave is
  // simply waited out; read data and the error bit are taken at that same edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for an answer that never comes.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: verification/rtc_update_and_control_tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Bench: register table, reset pin, square wave, update and freeze.
module rtc_update_and_control_tb_top
  import rtcu_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] r;
  } rtcu_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_n = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e, prev;
  logic strobe, bin, h24, dst, sq, irq_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  rtcu_time_s time_now = '0;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, t1, n;
  // Address, data written, data read back.
  rtcu_row_s rows [8] = '{
    '{ADDR_CTRL_A, 32'h0000000F, 32'h0000000F},
    '{ADDR_CTRL_A, 32'h00000065, 32'h00000065},
    '{ADDR_CTRL_A, 32'h0000008A, 32'h0000000A},
    '{ADDR_CTRL_B, 32'h0000007E, 32'h0000007E},
    '{ADDR_CTRL_B, 32'h00000090, 32'h00000080},
    '{ADDR_CTRL_B, 32'h00000005, 32'h00000005},
    '{ADDR_ALARM, 32'hFFC1C2C3, 32'h00C1C2C3},
    '{ADDR_TIME, 32'h00FFFFFF, 32'h00000000}
  };

  // A short tick keeps one second near 65536 clocks.
  rtcu_top #(.CLK_PER_TICK(2)) dut (.MCLK(mclk), .RST_N(rst_n), .RESET_PIN_N(pin_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIME_NOW(time_now),
    .UPDATE_STROBE(strobe), .BINARY_MODE(bin), .HOUR24_MODE(h24), .SUMMER_TIME_EN(dst),
    .SQUARE_OUT(sq), .IRQ_N_O(), .IRQ_N_OE(irq_oe));
  rtcu_host_model u_host (.clk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================
  // Clock, cycle count and helpers.
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp, msg);
  endtask
  // Polling stays bounded; a flag that never rises ends in a failed check later.
  task automatic wait_pending();
    n = 0;
    do begin
      u_host.xfer(1'b0, ADDR_CTRL_A, 32'h0, q, e);
      n++;
    end while (q[A_UIP] !== 1'b1 && n < 20000);
    t1 = cyc;
  endtask
  task automatic wait_strobe();
    n = 0;
    while (strobe !== 1'b1 && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    check({31'h0, n < 40000}, 32'h1, "update strobe");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog sized above the two half-second waits.
  initial begin
    #320000;
    num_errors++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_A, 32'h0, "ctrl A reset");
    rd(ADDR_CTRL_B, 32'h0, "ctrl B reset");
    u_host.xfer(1'b0, 8'h14, 32'h0, q, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r, "row readback");
    end
    check({29'h0, bin, h24, dst}, 32'h5, "format outputs");
    $display("register table done");
    // Pin reset clears only the enables and the flags.
    wr(ADDR_CTRL_A, 32'h03);
    wr(ADDR_CTRL_B, 32'hFF);
    pin_n <= 1'b0;
    repeat (5) @(posedge mclk);
    pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(ADDR_CTRL_B, 32'h87, "enables cleared");
    rd(ADDR_CTRL_A, 32'h03, "rate kept");
    $display("reset pin done");
    // Rate 3 gives a period of four ticks, eight clocks.
    wr(ADDR_CTRL_A, 32'h23);
    t0 = cyc;
    wr(ADDR_CTRL_B, 32'h08);
    n = 0;
    prev = sq;
    repeat (64) begin
      @(negedge mclk);
      if (sq === 1'b1 && prev === 1'b0) n++;
      prev = sq;
    end
    check({31'h0, n inside {[7:9]}}, 32'h1, "square rises");
    wr(ADDR_CTRL_B, 32'h00);
    @(posedge mclk);
    repeat (8) begin
      @(negedge mclk);
      check({31'h0, sq}, 32'h0, "square low");
    end
    wr(ADDR_CTRL_A, 32'h20);
    rd(ADDR_FLAGS, 32'h40, "periodic flag");
    rd(ADDR_FLAGS, 32'h00, "flags cleared");
    $display("square wave done");
    // First update, with alarm all don't-care.
    time_now <= 24'h123456;
    wr(ADDR_ALARM, 32'h00C0C0C0);
    wr(ADDR_CTRL_B, 32'h30);
    wait_pending();
    wait_strobe();
    check({31'h0, (cyc - t0) inside {[32760:32776]}}, 32'h1, "first update");
    check({31'h0, (cyc - t1) inside {[13:16]}}, 32'h1, "pending lead");
    rd(ADDR_CTRL_A, 32'hA0, "pending in cycle");
    repeat (130) @(posedge mclk);
    rd(ADDR_CTRL_A, 32'h20, "pending ended");
    @(negedge mclk);
    check({31'h0, irq_oe}, 32'h1, "irq on");
    rd(ADDR_TIME, 32'h00123456, "time loaded");
    rd(ADDR_FLAGS, 32'hB0, "alarm and done");
    @(negedge mclk);
    check({31'h0, irq_oe}, 32'h0, "irq off");
    $display("update done");
    // Freeze written while the pending flag is up.
    wr(ADDR_CTRL_A, 32'h70);
    wr(ADDR_CTRL_A, 32'h20);
    t0 = cyc;
    time_now <= 24'h010203;
    wait_pending();
    wr(ADDR_CTRL_B, 32'hB0);
    wait_strobe();
    check({31'h0, (cyc - t0) inside {[32760:32776]}}, 32'h1, "restart");
    rd(ADDR_CTRL_A, 32'h20, "pending cleared");
    rd(ADDR_CTRL_B, 32'hA0, "done enable cleared");
    repeat (130) @(posedge mclk);
    rd(ADDR_TIME, 32'h00123456, "time frozen");
    $display("freeze done");
    report_and_stop();
  end
endmodule
